// *** bgr_arbiter.sv ***
// Notes on behaviour
// - The arbiter returns the grant high once it sees the busy line low.
// - On busy release the arbiter grants a level whose request is low.
// - The on-board master drops wants-bus once its transfers are done.
// - A requester robbed upstream keeps requesting until a later grant.
`timescale 1ns/1ps
`default_nettype none

`include "bgr_cfg.svh"

module bgr_arbiter #(
  parameter int N_LVL    = `BGR_N_LVL_DEF,
  parameter int CNT_W    = `BGR_CNT_W_DEF,
  parameter int XFER_CYC = `BGR_XFER_CYC_DEF
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Backplane arbitration lines, active low.
  input  wire logic [N_LVL-1:0] br_n,
  input  wire logic             bbsy_n,
  output logic      [N_LVL-1:0] bg_n,
  // On-board master link to its requester.
  input  wire logic             granted,
  output logic                  wants_bus,
  // Master command port, same clock.
  input  wire logic             xfer_start,
  input  wire logic [CNT_W-1:0] xfer_count,
  output logic                  xfer_active,
  output logic                  xfer_done
);

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************

  generate
    if (N_LVL < 1 || N_LVL > 8 || CNT_W < 1 || XFER_CYC < 1) begin : g_chk
      $error("bgr_arbiter: unsupported parameter values.");
    end
  endgenerate

  localparam int CYC_W = $clog2(XFER_CYC + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(XFER_CYC - 1);

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************

  logic [N_LVL-1:0] br_n_s;
  logic             bbsy_n_s;
  logic             granted_s;

  bgr_sync #(
    .W    (N_LVL),
    .IDLE ({N_LVL{1'b1}})
  ) u_sync_br (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (br_n),
    .sync_out (br_n_s)
  );

  bgr_sync #(
    .W    (2),
    .IDLE (2'b10)
  ) u_sync_misc (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in ({bbsy_n, granted}),
    .sync_out ({bbsy_n_s, granted_s})
  );

  // ****************************************************************
  // Priority pick: highest pending level wins.
  // ****************************************************************

  function automatic logic [N_LVL-1:0] pick(input logic [N_LVL-1:0] req_n);
    logic [N_LVL-1:0] sel;
    logic             found;
    sel   = '0;
    found = 1'b0;
    for (int i = N_LVL - 1; i >= 0; i--) begin
      if (!req_n[i] && !found) begin
        sel[i] = 1'b1;
        found  = 1'b1;
      end
    end
    return sel;
  endfunction : pick

  // ****************************************************************
  // Arbiter state machine.
  // ****************************************************************

  bgr_pkg::bgr_arb_state_t arb_state;
  bgr_pkg::bgr_arb_state_t next_arb_state;
  logic [N_LVL-1:0]        next_bg_n;
  logic [N_LVL-1:0]        win;

  always_comb begin
    next_arb_state = arb_state;
    next_bg_n      = bg_n;
    win            = pick(br_n_s);
    case (arb_state)
      bgr_pkg::BGR_ARB_IDLE: begin
        // A new grant waits for busy high, keeping the handshake interlocked.
        if (bbsy_n_s && (win != '0)) begin
          next_bg_n      = ~win;
          next_arb_state = bgr_pkg::BGR_ARB_GRANT;
        end
      end
      bgr_pkg::BGR_ARB_GRANT: begin
        if (!bbsy_n_s) begin
          next_bg_n      = {N_LVL{`BGR_GRANT_IDLE}};
          next_arb_state = bgr_pkg::BGR_ARB_HELD;
        end
      end
      bgr_pkg::BGR_ARB_HELD: begin
        // A grant taken upstream leaves its request pending for this pass.
        if (bbsy_n_s) begin
          next_arb_state = bgr_pkg::BGR_ARB_IDLE;
        end
      end
      default: begin
        next_bg_n      = {N_LVL{`BGR_GRANT_IDLE}};
        next_arb_state = bgr_pkg::BGR_ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arb_state <= bgr_pkg::BGR_ARB_IDLE;
      bg_n      <= {N_LVL{`BGR_GRANT_IDLE}};
    end else begin
      arb_state <= next_arb_state;
      bg_n      <= next_bg_n;
    end
  end

  // ****************************************************************
  // On-board master.
  // ****************************************************************

  bgr_pkg::bgr_mst_state_t mst_state;
  bgr_pkg::bgr_mst_state_t next_mst_state;
  logic [CNT_W-1:0]        left;
  logic [CNT_W-1:0]        next_left;
  logic [CYC_W-1:0]        cyc;
  logic [CYC_W-1:0]        next_cyc;
  logic                    next_wants_bus;
  logic                    next_xfer_active;
  logic                    next_xfer_done;

  always_comb begin
    next_mst_state   = mst_state;
    next_left        = left;
    next_cyc         = cyc;
    next_wants_bus   = wants_bus;
    next_xfer_active = xfer_active;
    next_xfer_done   = 1'b0;
    case (mst_state)
      bgr_pkg::BGR_MST_IDLE: begin
        // A zero count is ignored; no bus is asked for.
        if (xfer_start && (xfer_count != '0) && !granted_s) begin
          next_left      = xfer_count;
          next_wants_bus = 1'b1;
          next_mst_state = bgr_pkg::BGR_MST_WAIT;
        end
      end
      bgr_pkg::BGR_MST_WAIT: begin
        if (granted_s) begin
          next_cyc         = '0;
          next_xfer_active = 1'b1;
          next_mst_state   = bgr_pkg::BGR_MST_XFER;
        end
      end
      bgr_pkg::BGR_MST_XFER: begin
        if (cyc == CYC_LAST) begin
          next_cyc = '0;
          if (left == CNT_W'(1)) begin
            next_left        = '0;
            next_wants_bus   = 1'b0;
            next_xfer_active = 1'b0;
            next_xfer_done   = 1'b1;
            next_mst_state   = bgr_pkg::BGR_MST_DONE;
          end else begin
            next_left = left - CNT_W'(1);
          end
        end else begin
          next_cyc = cyc + CYC_W'(1);
        end
      end
      bgr_pkg::BGR_MST_DONE: begin
        // Waiting for the requester to drop granted avoids a stale grant.
        if (!granted_s) begin
          next_mst_state = bgr_pkg::BGR_MST_IDLE;
        end
      end
      default: begin
        next_wants_bus   = 1'b0;
        next_xfer_active = 1'b0;
        next_mst_state   = bgr_pkg::BGR_MST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mst_state   <= bgr_pkg::BGR_MST_IDLE;
      left        <= '0;
      cyc         <= '0;
      wants_bus   <= 1'b0;
      xfer_active <= 1'b0;
      xfer_done   <= 1'b0;
    end else begin
      mst_state   <= next_mst_state;
      left        <= next_left;
      cyc         <= next_cyc;
      wants_bus   <= next_wants_bus;
      xfer_active <= next_xfer_active;
      xfer_done   <= next_xfer_done;
    end
  end

endmodule : bgr_arbiter

`default_nettype wire

// *** bgr_cfg.svh ***
`ifndef BGR_CFG_SVH
`define BGR_CFG_SVH

// ****************************************************************
// Arbiter and master timing and reset values.
// ****************************************************************

`define BGR_N_LVL_DEF      4
`define BGR_CNT_W_DEF      8
`define BGR_XFER_CYC_DEF   4
`define BGR_SYNC_STAGES    2
`define BGR_GRANT_IDLE     1'b1
`define BGR_BUSY_IDLE      1'b1

`endif

// *** bgr_pkg.sv ***
package bgr_pkg;

  // ****************************************************************
  // State types.
  // ****************************************************************

  typedef enum logic [1:0] {
    BGR_ARB_IDLE  = 2'b00,
    BGR_ARB_GRANT = 2'b01,
    BGR_ARB_HELD  = 2'b10
  } bgr_arb_state_t;

  typedef enum logic [1:0] {
    BGR_MST_IDLE = 2'b00,
    BGR_MST_WAIT = 2'b01,
    BGR_MST_XFER = 2'b10,
    BGR_MST_DONE = 2'b11
  } bgr_mst_state_t;

endpackage : bgr_pkg

// *** bgr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser, reset to a given idle level.
module bgr_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Asynchronous input and synchronised output.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= IDLE;
      stage2 <= IDLE;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule : bgr_sync

`default_nettype wire

// *** bgr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Arbiter and master checks.
// ****
module bgr_checker #(
  parameter int N_LVL = 4
) (
  // Clock and reset.
  input wire logic             sys_clk,
  input wire logic             nrst,
  // Backplane lines.
  input wire logic [N_LVL-1:0] br_n,
  input wire logic             bbsy_n,
  input wire logic [N_LVL-1:0] bg_n,
  // Master side.
  input wire logic             wants_bus,
  input wire logic             xfer_active,
  input wire logic             xfer_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Busy must be seen through the synchroniser before the grant lifts.
  sequence s_busy_seen; !bbsy_n [*3]; endsequence
  sequence s_free_req; (bbsy_n && br_n != '1) [*6]; endsequence
  AST_GRANT_UP: assert property (s_busy_seen |=> bg_n == '1)
    else $error("grant held low while busy");
  AST_REGRANT: assert property (s_free_req |=> bg_n != '1)
    else $error("pending request not granted");
  AST_ONE_GRANT: assert property (bg_n == '1 || $onehot(~bg_n))
    else $error("several grants low");
  AST_WANT_HELD: assert property (xfer_active |-> wants_bus)
    else $error("wants bus dropped during transfers");
  AST_XFER_MIN: assert property (
      $rose(xfer_active) |-> xfer_active [*4])
    else $error("transfer shorter than one unit");
  AST_DONE_DROP: assert property (
      $fell(xfer_active) |-> xfer_done && !wants_bus)
    else $error("wants bus kept after last transfer");
  AST_DONE_PULSE: assert property (xfer_done |=> !xfer_done)
    else $error("done longer than one cycle");
endmodule : bgr_checker
`default_nettype wire

// *** bgr_req_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Requester model, clocked for simplicity.
// ****
module bgr_req_model #(
  parameter int N_LVL = 4
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Release on request when high.
  input  wire logic             ror,
  // Backplane side.
  input  wire logic [N_LVL-1:0] br_n,
  input  wire logic             bg_in_n,
  output logic                  req_n,
  output logic                  bbsy_n,
  output logic                  bg_out_n,
  // Master side.
  input  wire logic             wants_bus,
  output logic                  granted
);
  realtime t_rel;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_n <= 1'b1;
      bbsy_n <= 1'b1;
      bg_out_n <= 1'b1;
      granted <= 1'b0;
      t_rel <= 0.0;
    end else begin
      if (wants_bus && bbsy_n && !granted && bg_in_n)
        req_n <= 1'b0;
      if (!bg_in_n && bg_out_n && wants_bus
          && bbsy_n && !granted) begin
        bbsy_n <= 1'b0;
        req_n <= 1'b1;
        granted <= 1'b1;
        t_rel <= $realtime;
      end
      // The pass decision is taken once per grant, so no short pulse.
      bg_out_n <= bg_in_n
                  | (bg_out_n & (wants_bus | !bbsy_n));
      if (!bbsy_n && ror)
        granted <= wants_bus;
      if (!bbsy_n && !ror && !wants_bus && bg_in_n
          && $realtime - t_rel >= 30.0) begin
        bbsy_n <= 1'b1;
        granted <= 1'b0;
      end
      if (!bbsy_n && ror && bg_in_n && req_n && br_n != '1) begin
        bbsy_n <= 1'b1;
        granted <= 1'b0;
      end
    end
  end
endmodule : bgr_req_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] cnt; logic [15:0] act;} bgr_row_t;
  bgr_row_t   rows [4] = '{'{8'h01, 16'h0004}, '{8'h02, 16'h0008},
                           '{8'h05, 16'h0014}, '{8'h00, 16'h0000}};
  logic       sys_clk, nrst, ror, xfer_start, tb_bbsy_n, m_bbsy_n, req_n;
  logic       bbsy_n, granted, wants_bus, xfer_active, xfer_done;
  logic [3:0] tb_br_n, br_n, bg_n;
  logic [7:0] xfer_count;
  int         num_errors, n_checks, cyc;
  logic [15:0] act, got_done;
  assign br_n = tb_br_n & {2'b11, req_n, 1'b1};
  assign bbsy_n = m_bbsy_n & tb_bbsy_n;
  bgr_arbiter bgr_arbiter_inst (.sys_clk, .nrst, .br_n, .bbsy_n, .bg_n,
    .granted, .wants_bus, .xfer_start, .xfer_count, .xfer_active, .xfer_done);
  bgr_req_model bgr_req_model_inst (.sys_clk, .nrst, .ror, .br_n,
    .bg_in_n(bg_n[1]), .req_n, .bbsy_n(m_bbsy_n), .bg_out_n(), .wants_bus,
    .granted);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic start(logic [7:0] cnt);
    @(posedge sys_clk) #1 xfer_start = 1'b1;
    xfer_count = cnt;
    @(posedge sys_clk) #1 xfer_start = 1'b0;
  endtask : start
  task automatic finish();
    act = '0;
    for (int k = 0; k < 200 && xfer_done !== 1'b1; k++)
      @(posedge sys_clk) #1 act += 16'(xfer_active);
    got_done = 16'(xfer_done);
    repeat (12) @(posedge sys_clk);
    #1;
  endtask : finish
  task automatic wait_bg(logic [3:0] v);
    for (int k = 0; k < 50 && bg_n !== v; k++) @(posedge sys_clk) #1;
    check("bg_n", bg_n, v);
  endtask : wait_bg
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    {nrst, ror, xfer_start, xfer_count, num_errors, n_checks} = '0;
    {tb_br_n, tb_bbsy_n} = 5'h1f;
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check("reset", {bg_n, wants_bus, xfer_active, xfer_done}, 16'h0078);
    foreach (rows[i]) begin
      start(rows[i].cnt);
      finish();
      check("active", act, rows[i].act);
      check("done", got_done, 16'(rows[i].cnt != 8'h00));
      check("busy", {bbsy_n, bg_n}, 16'h001f);
      $display("row %0d done", i);
    end
    // A higher level keeps the local request pending.
    tb_br_n = 4'h7;
    wait_bg(4'h7);
    start(8'h01);
    tb_bbsy_n = 1'b0;
    tb_br_n = 4'hf;
    wait_bg(4'hf);
    tb_bbsy_n = 1'b1;
    wait_bg(4'hd);
    finish();
    check("active", act, 16'h0004);
    $display("priority done");
    // Release on request: the bus is kept until another level asks.
    ror = 1'b1;
    start(8'h01);
    finish();
    check("busy", {bbsy_n, bg_n}, 16'h000f);
    start(8'h02);
    finish();
    check("active", act, 16'h0008);
    tb_br_n = 4'hb;
    wait_bg(4'hb);
    tb_bbsy_n = 1'b0;
    tb_br_n = 4'hf;
    wait_bg(4'hf);
    tb_bbsy_n = 1'b1;
    ror = 1'b0;
    $display("release on request done");
    // Reset in mid transfer.
    start(8'h05);
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b0;
    #1 check("reset", {bg_n, wants_bus, xfer_active, xfer_done}, 16'h0078);
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b1;
    start(8'h01);
    finish();
    check("active", act, 16'h0004);
    check("done", got_done, 16'h0001);
    check("busy", {bbsy_n, bg_n}, 16'h001f);
    $display("mid reset done");
    tally_and_finish();
  end
endmodule : tb_top
bind bgr_arbiter bgr_checker #(.N_LVL(N_LVL)) bgr_checker_inst (.sys_clk,
  .nrst, .br_n, .bbsy_n, .bg_n, .wants_bus, .xfer_active, .xfer_done);
`default_nettype wire
